/* design/cfs_fault_supervisor.sv */
// Fault supervisor that gates the CAN transmit path of the transceiver.
// Assumes tx_in, rx_echo and bus_rx synchronous to clk; 0 is dominant.
`timescale 1ns/100ps
`include "cfs_regs.svh"

// What this block does
// - Four missed receive echoes of dominant transmit disable the transmitter.
// - Receive-stuck-recessive fault latches a status flag, read and cleared serially.
// - Disabling faults keep the bus recessive until the status flag is cleared.
// - Transmit input dominant beyond about 700 us is a timeout fault.
// - Bus dominant beyond 700 us flags a permanent dominant fault.
// - All checks set one common flag; one disable bit turns checking off.
// - Transmit dominant with receive not following four times disables and latches.
// - Permanent dominant bus latches the flag but keeps the transmitter enabled.
// - During reset the transmit input is ignored and the bus held recessive.
module cfs_fault_supervisor import cfs_pkg::*; #(
    parameter int TXD_TOUT_CYC  = `CFS_TXD_TOUT_CYC,
    parameter int BUS_TOUT_CYC  = `CFS_BUS_TOUT_CYC,
    parameter int ECHO_WAIT_CYC = `CFS_ECHO_WAIT_CYC,
    parameter int MISS_LIMIT    = `CFS_ECHO_MISS_LIMIT
) (
    input  wire logic clk,                 // 10 MHz clock
    input  wire logic sys_rst,             // Synchronous reset, active high
    input  wire logic tx_in,               // Controller transmit, 0 dominant
    input  wire logic rx_echo,             // Internal receive echo
    input  wire logic bus_rx,              // Receiver bus state, 0 dominant
    input  wire logic fault_check_disable, // Turns all fault detection off
    input  wire logic status_clear,        // Serial write clearing the flag, pulse
    output logic      tx_drive,            // To driver, 0 dominant
    output logic      rx_out,              // To controller receive pin
    output logic      bus_fault,           // Common latched fault flag
    output logic      tx_disabled,         // Transmitter blocked by a fault
    output logic      txd_timeout,         // Transmit dominant timeout seen
    output logic      rx_recessive_fault,  // Receive stuck recessive seen
    output logic      bus_dominant_fault   // Permanent dominant bus seen
);

    localparam int CW = $clog2(TXD_TOUT_CYC > BUS_TOUT_CYC ? TXD_TOUT_CYC + 2
                                                            : BUS_TOUT_CYC + 2);
    localparam int EW = $clog2(ECHO_WAIT_CYC + 2);
    localparam int MW = $clog2(MISS_LIMIT + 1);

    // Counts below 1 would leave a check that fires at once instead of waiting
    if (TXD_TOUT_CYC < 1) begin : g_bad_txd_tout
        $error("cfs_fault_supervisor: TXD_TOUT_CYC must be at least 1");
    end
    if (BUS_TOUT_CYC < 1) begin : g_bad_bus_tout
        $error("cfs_fault_supervisor: BUS_TOUT_CYC must be at least 1");
    end
    if (ECHO_WAIT_CYC < 1) begin : g_bad_echo_wait
        $error("cfs_fault_supervisor: ECHO_WAIT_CYC must be at least 1");
    end
    if (MISS_LIMIT < 1) begin : g_bad_miss_limit
        $error("cfs_fault_supervisor: MISS_LIMIT must be at least 1");
    end

    cfs_echo_e       echo_state;
    cfs_echo_e       next_echo_state;
    logic [CW-1:0]   txd_cnt;
    logic [CW-1:0]   bus_cnt;
    logic [EW-1:0]   wait_cnt;
    logic [MW-1:0]   miss_cnt;
    logic            tx_prev;
    logic            tx_fall;
    logic            clr_cnt;
    logic            echo_miss;
    logic            txd_hit;
    logic            bus_hit;
    logic            miss_hit;
    logic            block_hit;
    logic            checks_on;

    // Saturates so a long dominant run never wraps back onto the limit
    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
        return (v == {CW{1'b1}}) ? v : v + CW'(1);
    endfunction

    // Level test shared by every pin check
    function automatic logic is_dom(input logic v);
        return v == `CFS_DOMINANT;
    endfunction

    assign checks_on = !fault_check_disable;
    assign clr_cnt   = sys_rst || status_clear || !checks_on;
    assign tx_fall   = !is_dom(tx_prev) && is_dom(tx_in);
    assign txd_hit   = checks_on && (txd_cnt == CW'(TXD_TOUT_CYC)) &&
                       is_dom(tx_in);
    assign bus_hit   = checks_on && (bus_cnt == CW'(BUS_TOUT_CYC)) &&
                       is_dom(bus_rx);
    assign echo_miss = checks_on && (echo_state == CFS_ECHO_WAIT) && !is_dom(rx_echo) &&
                       (wait_cnt == EW'(ECHO_WAIT_CYC));
    assign miss_hit  = echo_miss && (miss_cnt == MW'(MISS_LIMIT - 1));
    assign block_hit = txd_hit || miss_hit;

    // Transmit dominant duration
    always_ff @(posedge clk) begin
        if (clr_cnt || !is_dom(tx_in)) begin
            txd_cnt <= '0;
        end else begin
            txd_cnt <= sat_inc(txd_cnt);
        end
    end

    // Bus dominant duration
    always_ff @(posedge clk) begin
        if (clr_cnt || !is_dom(bus_rx)) begin
            bus_cnt <= '0;
        end else begin
            bus_cnt <= sat_inc(bus_cnt);
        end
    end

    // Previous transmit level; reset to idle so a transmit input dominant at reset exit counts as an edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_prev <= `CFS_RECESSIVE;
        end else begin
            tx_prev <= tx_in;
        end
    end

    // Echo window opened by each falling transmit edge
    always_comb begin
        next_echo_state = echo_state;
        case (echo_state)
            CFS_ECHO_IDLE: begin
                if (tx_fall) begin
                    next_echo_state = CFS_ECHO_WAIT;
                end
            end
            CFS_ECHO_WAIT: begin
                if (is_dom(rx_echo) || echo_miss) begin
                    next_echo_state = CFS_ECHO_HELD;
                end else if (!is_dom(tx_in)) begin
                    next_echo_state = CFS_ECHO_IDLE;
                end
            end
            CFS_ECHO_HELD: begin
                if (!is_dom(tx_in)) begin
                    next_echo_state = CFS_ECHO_IDLE;
                end
            end
            default: next_echo_state = CFS_ECHO_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (clr_cnt) begin
            echo_state <= CFS_ECHO_IDLE;
        end else begin
            echo_state <= next_echo_state;
        end
    end

    // Cycles spent waiting for the echo
    always_ff @(posedge clk) begin
        if (clr_cnt || echo_state != CFS_ECHO_WAIT) begin
            wait_cnt <= '0;
        end else begin
            wait_cnt <= wait_cnt + EW'(1);
        end
    end

    // Missed echoes; good echoes do not undo earlier misses
    always_ff @(posedge clk) begin
        if (clr_cnt) begin
            miss_cnt <= '0;
        end else if (echo_miss && !miss_hit) begin
            miss_cnt <= miss_cnt + MW'(1);
        end
    end

    // Sticky flags below: a new fault wins over a clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txd_timeout <= 1'b0;
        end else begin
            txd_timeout <= txd_hit || (txd_timeout && !status_clear);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_recessive_fault <= 1'b0;
        end else begin
            rx_recessive_fault <= miss_hit || (rx_recessive_fault && !status_clear);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_dominant_fault <= 1'b0;
        end else begin
            bus_dominant_fault <= bus_hit || (bus_dominant_fault && !status_clear);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_fault <= 1'b0;
        end else begin
            bus_fault <= block_hit || bus_hit ||
                         (bus_fault && !status_clear);
        end
    end

    // Blocking faults hold the driver off until cleared
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_disabled <= 1'b0;
        end else begin
            tx_disabled <= block_hit || (tx_disabled && !status_clear);
        end
    end

    // Driver forced recessive from the detecting edge on
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_drive <= `CFS_RECESSIVE;
        end else begin
            tx_drive <= (tx_disabled || block_hit) ? `CFS_RECESSIVE : tx_in;
        end
    end

    // Bus state passed on to the controller
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_out <= `CFS_RECESSIVE;
        end else begin
            rx_out <= bus_rx;
        end
    end

endmodule // cfs_fault_supervisor

/* design/cfs_regs.svh */
// Constants of the CAN fault supervisor: timeouts and counts.
// Assumes a 10 MHz system clock; included by its bare name.
`ifndef CFS_REGS_SVH
`define CFS_REGS_SVH

`define CFS_CLK_HZ          10000000
`define CFS_TXD_TOUT_US     700
`define CFS_TXD_TOUT_MIN_US 525
`define CFS_TXD_TOUT_MAX_US 875
`define CFS_BUS_TOUT_US     700
`define CFS_TXD_TOUT_CYC    ((`CFS_TXD_TOUT_US * (`CFS_CLK_HZ / 1000)) / 1000)
`define CFS_BUS_TOUT_CYC    ((`CFS_BUS_TOUT_US * (`CFS_CLK_HZ / 1000)) / 1000)
`define CFS_ECHO_MISS_LIMIT 4
`define CFS_ECHO_WAIT_CYC   4
`define CFS_DOMINANT        1'b0
`define CFS_RECESSIVE       1'b1

`endif

/* design/cfs_pkg.sv */
// Types of the CAN fault supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package cfs_pkg;
    typedef enum logic [1:0] {
        CFS_ECHO_IDLE = 2'b00,
        CFS_ECHO_WAIT = 2'b01,
        CFS_ECHO_HELD = 2'b10
    } cfs_echo_e;
endpackage

/* verif/cfs_checker_properties.sv */
// Port checker for the CAN fault supervisor.
// Bound to every supervisor instance at the foot.
`timescale 1ns/100ps
module cfs_checker #(
    parameter int TXD_TOUT_CYC = 20,
    parameter int BUS_TOUT_CYC = 20,
    parameter int MISS_LIMIT   = 4
) (
    input wire logic clk,                 // System clock
    input wire logic sys_rst,             // Synchronous reset
    input wire logic tx_in,               // Controller transmit
    input wire logic bus_rx,              // Bus state
    input wire logic fault_check_disable, // Checks off
    input wire logic status_clear,        // Flag clear pulse
    input wire logic tx_drive,            // Driver input
    input wire logic rx_out,              // Controller receive
    input wire logic bus_fault,           // Common flag
    input wire logic tx_disabled,         // Transmitter blocked
    input wire logic txd_timeout,         // Transmit timeout flag
    input wire logic rx_recessive_fault,  // Echo fault flag
    input wire logic bus_dominant_fault   // Bus dominant flag
);
    int   tcnt, bcnt, falls;
    logic tx_prev, clr;
    assign clr = sys_rst | status_clear | fault_check_disable;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Dominant run lengths and dominant starts
    always_ff @(posedge clk) begin
        tx_prev <= tx_in;
        tcnt    <= (clr | tx_in) ? 0 : tcnt + 1;
        bcnt    <= (clr | bus_rx) ? 0 : bcnt + 1;
        falls   <= clr ? 0 : falls + int'(tx_prev & ~tx_in);
    end
    sequence s_block_fault;
        $rose(txd_timeout) || $rose(rx_recessive_fault);
    endsequence
    a_reset_recessive: assert property (disable iff (1'b0)
        sys_rst |=> tx_drive && !bus_fault && !tx_disabled) else $error("reset state");
    a_tx_follow: assert property (!tx_disabled && !$past(tx_disabled) && !$past(sys_rst)
        |-> tx_drive == $past(tx_in)) else $error("drive not following");
    a_block_hold: assert property (tx_disabled && !status_clear
        |=> tx_disabled && tx_drive) else $error("block lost");
    a_block_cause: assert property (s_block_fault |-> tx_disabled) else $error("no block");
    a_bus_keeps_tx: assert property ($rose(bus_dominant_fault) && !txd_timeout
        && !rx_recessive_fault |-> !tx_disabled) else $error("bus fault blocked");
    a_common_flag: assert property (txd_timeout || rx_recessive_fault || bus_dominant_fault
        |-> bus_fault) else $error("common flag low");
    a_flag_sticky: assert property (bus_fault && !status_clear |=> bus_fault) else $error("flag lost");
    a_disable_quiet: assert property (fault_check_disable && !bus_fault
        |=> !bus_fault) else $error("fault while off");
    a_txd_timeout: assert property (tcnt == TXD_TOUT_CYC + 2 && !tx_disabled
        |-> ##[0:2] txd_timeout) else $error("timeout missed");
    a_txd_early: assert property ($rose(txd_timeout) |-> tcnt >= TXD_TOUT_CYC) else $error("early");
    a_bus_timeout: assert property (bcnt == BUS_TOUT_CYC + 2
        |-> ##[0:2] bus_dominant_fault) else $error("bus timeout missed");
    a_echo_count: assert property ($rose(rx_recessive_fault)
        |-> falls >= MISS_LIMIT) else $error("echo fault early");
    a_rx_follow: assert property (!$past(sys_rst)
        |-> rx_out == $past(bus_rx)) else $error("receive not following");
endmodule // cfs_checker
bind cfs_fault_supervisor cfs_checker #(.TXD_TOUT_CYC(TXD_TOUT_CYC),
    .BUS_TOUT_CYC(BUS_TOUT_CYC), .MISS_LIMIT(MISS_LIMIT)) u_chk (.clk, .sys_rst, .tx_in,
    .bus_rx, .fault_check_disable, .status_clear, .tx_drive, .rx_out, .bus_fault, .tx_disabled,
    .txd_timeout, .rx_recessive_fault, .bus_dominant_fault);

/* verif/cfs_ctrl_model.sv */
// Protocol controller model driving the transmit pin.
// Echo path can be broken; changes just after clk edges.
`timescale 1ns/100ps
module cfs_ctrl_model (
    input  wire logic clk,       // System clock
    input  wire logic tx_req,    // Level to send
    input  wire logic echo_good, // Echo path healthy
    output logic      tx_in,     // Supervisor transmit input
    output logic      rx_echo    // Internal receive echo
);
    always @(posedge clk) begin
        tx_in   <= tx_req;
        rx_echo <= echo_good ? tx_in : 1'b1;
    end
endmodule // cfs_ctrl_model

/* verif/tb.sv */
// Self-checking bench for the CAN fault supervisor.
// Short timeouts of 20 cycles; checker bound in.
`timescale 1ns/100ps
module tb;
    logic clk = 0, sys_rst = 1, tx_req = 0, echo_good = 0, bus_rx = 1;
    logic fault_check_disable = 0, status_clear = 0, tx_in, rx_echo, tx_drive, rx_out;
    logic bus_fault, tx_disabled, txd_timeout, rx_recessive_fault, bus_dominant_fault;
    int   n_mismatch = 0, checks = 0;
    always #50 clk = ~clk;
    cfs_ctrl_model u_ctrl (.clk, .tx_req, .echo_good, .tx_in, .rx_echo);
    cfs_fault_supervisor #(.TXD_TOUT_CYC(20), .BUS_TOUT_CYC(20)) DUT (.clk, .sys_rst,
        .tx_in, .rx_echo, .bus_rx, .fault_check_disable, .status_clear, .tx_drive, .rx_out,
        .bus_fault, .tx_disabled, .txd_timeout, .rx_recessive_fault, .bus_dominant_fault);
    task automatic cyc(int n); repeat (n) @(posedge clk); endtask
    task automatic chk(string s, logic [4:0] got, logic [4:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", s, exp, got);
        end
    endtask
    // Flags: common, blocked, timeout, echo, bus dominant
    task automatic fl(logic [4:0] e);
        @(negedge clk) chk("flags", {bus_fault, tx_disabled, txd_timeout,
            rx_recessive_fault, bus_dominant_fault}, e);
    endtask
    task automatic clr;
        @(posedge clk) status_clear <= 1'b1;
        @(posedge clk) status_clear <= 1'b0;
    endtask
    task automatic pulse(logic good);
        @(posedge clk) tx_req <= 1'b0;
        echo_good <= good;
        cyc(8);
        @(posedge clk) tx_req <= 1'b1;
        cyc(4);
    endtask
    task automatic t_timeout;
        @(posedge clk) tx_req <= 1'b0;
        cyc(15);
        clr();
        cyc(14);
        fl(5'h00);
        cyc(12);
        fl(5'h1C);
        chk("tx_drive", {4'h0, tx_drive}, 5'h01);
        @(posedge clk) tx_req <= 1'b1;
        cyc(3);
        fl(5'h1C);
        clr();
        fl(5'h00);
        $display("timeout test done");
    endtask
    task automatic t_echo;
        for (int i = 0; i < 5; i++) begin
            pulse(i == 3);
            fl((i == 4) ? 5'h1A : 5'h00);
        end
        clr();
        $display("echo test done");
    endtask
    task automatic t_bus;
        echo_good <= 1'b1;
        @(posedge clk) bus_rx <= 1'b0;
        cyc(25);
        fl(5'h11);
        chk("rx_out", {4'h0, rx_out}, 5'h00);
        @(posedge clk) tx_req <= 1'b0;
        cyc(2);
        @(negedge clk) chk("tx_drive", {4'h0, tx_drive}, 5'h00);
        @(posedge clk) tx_req <= 1'b1;
        bus_rx <= 1'b1;
        clr();
        $display("bus test done");
    endtask
    task automatic t_disable;
        @(posedge clk) fault_check_disable <= 1'b1;
        tx_req <= 1'b0;
        bus_rx <= 1'b0;
        cyc(30);
        fl(5'h00);
        chk("tx_drive", {4'h0, tx_drive}, 5'h00);
        @(posedge clk) tx_req <= 1'b1;
        bus_rx <= 1'b1;
        @(posedge clk) fault_check_disable <= 1'b0;
        $display("disable test done");
    endtask
    task automatic t_reset;
        @(posedge clk) tx_req <= 1'b0;
        cyc(25);
        fl(5'h1C);
        @(posedge clk) sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        @(negedge clk) chk("tx_drive", {4'h0, tx_drive}, 5'h01);
        fl(5'h00);
        cyc(14);
        fl(5'h00);
        chk("tx_drive", {4'h0, tx_drive}, 5'h00);
        @(posedge clk) tx_req <= 1'b1;
        $display("reset test done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        cyc(2);
        sys_rst <= 1'b0;
        tx_req  <= 1'b1;
        @(negedge clk) chk("tx_drive", {4'h0, tx_drive}, 5'h01);
        t_timeout;
        t_echo;
        t_bus;
        t_disable;
        t_reset;
        summarize;
    end
    initial begin
        cyc(1000);
        n_mismatch++;
        summarize;
    end
endmodule // tb
